//--- tb/eic_pin_src.sv
// Purpose: External sources on port 0 pins
// Assumes: Called from the bench clock
// Notes: Plain levels, no pulls
`timescale 1ns/1ps
module eic_pin_src (
	// Clock
	input wire logic sys_clk_in,
	// Pins
	output logic [7:0] pins_out
);
	initial pins_out = 8'h00;
	// Request held for cyc edges so the device can take it
	task automatic hold(input int idx, input logic lvl, input int cyc);
		@(posedge sys_clk_in);
		pins_out[idx] <= lvl;
		repeat (cyc) @(posedge sys_clk_in);
	endtask
endmodule

//--- tb/eic_top_checker.sv
// Purpose: Port checks for eic_top
// Assumes: Config mirrored from bus writes
// Notes: Mirror tracks only what the bus wrote
`timescale 1ns/1ps
module eic_top_checker (
	// Clock, reset and bus
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire eic_pkg::eic_sfr_req_t sfr_req_in,
	input wire logic [7:0] sfr_rdata_out,
	// Pins, vectors and flags
	input wire logic [7:0] port0_pins_in,
	input wire logic first_ext_vector_in,
	input wire logic second_ext_vector_in,
	input wire logic first_ext_pending_out,
	input wire logic second_ext_pending_out,
	input wire logic port_match_priority_out,
	input wire logic port_match_enable_out
);
	logic [7:0] cfg_q;
	logic [7:0] tc_q;
	wire w = sfr_req_in.wr;
	wire r = sfr_req_in.rd;
	wire [7:0] a = sfr_req_in.addr;
	wire a0 = port0_pins_in[cfg_q[2:0]] == cfg_q[3];
	wire a1 = port0_pins_in[cfg_q[6:4]] == cfg_q[7];
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cfg_q <= 8'h01;
			tc_q <= 8'h00;
		end else if (w && a == 8'he4) begin
			cfg_q <= sfr_req_in.wdata;
		end else if (w && a == 8'h88) begin
			tc_q <= sfr_req_in.wdata;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	prio_read_a: assert property (r && a == 8'hcf |=> sfr_rdata_out ==
		{6'h00, $past(port_match_priority_out), 1'b0}) else $error("prio rd");
	prio_write_a: assert property (w && a == 8'hcf |=>
		port_match_priority_out == $past(sfr_req_in.wdata[1])) else $error("pr");
	enable_write_a: assert property (w && a == 8'he7 |=>
		port_match_enable_out == $past(sfr_req_in.wdata[1])) else $error("en");
	timer_read_a: assert property (r && a == 8'h88 |=> sfr_rdata_out ==
		$past({4'h0, second_ext_pending_out, tc_q[2], first_ext_pending_out,
		tc_q[0]})) else $error("timer rd");
	level_on_a: assert property ((!tc_q[0] && a0 && $stable(cfg_q))[*5]
		|-> first_ext_pending_out) else $error("lvl on");
	level_off_a: assert property ((!tc_q[2] && !a1 && $stable(cfg_q))[*5]
		|-> !second_ext_pending_out) else $error("lvl off");
	vector_clear_a: assert property (tc_q[2] && second_ext_vector_in && !w &&
		a1 && $past(a1) && $past(a1, 2) && $past(a1, 3) |=>
		!second_ext_pending_out) else $error("vec clr");
	edge_set_a: assert property ((tc_q[0] && !a0 && $stable(cfg_q)) ##1
		(tc_q[0] && a0 && !first_ext_vector_in && !w)[*4]
		|-> first_ext_pending_out) else $error("edge set");
	cover property (first_ext_vector_in && first_ext_pending_out);
	cover property ($rose(second_ext_pending_out));
	cover property (r && a == 8'h88);
endmodule
bind eic_top eic_top_checker eic_top_checker_inst (.*);

//--- tb/eic_top_test.sv
// Purpose: Self-checking bench for eic_top
// Assumes: Pins come from eic_pin_src
// Notes: Short run, no long counts
`timescale 1ns/1ps
module eic_top_test;
	logic clk = 0;
	logic rst = 1;
	eic_pkg::eic_sfr_req_t q = '0;
	logic [7:0] rd;
	logic [7:0] pins;
	logic v0 = 0;
	logic v1 = 0;
	logic p0, p1, pp, pe;
	int err_count = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	eic_pin_src eic_pin_src_inst (.sys_clk_in(clk), .pins_out(pins));
	eic_top eic_top_inst (.sys_clk_in(clk), .sys_rst_in(rst),
		.sfr_req_in(q), .sfr_rdata_out(rd), .port0_pins_in(pins),
		.first_ext_vector_in(v0), .second_ext_vector_in(v1),
		.first_ext_pending_out(p0), .second_ext_pending_out(p1),
		.port_match_priority_out(pp), .port_match_enable_out(pe));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		if (err_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
		@(posedge clk);
		q <= {w, !w, ad, d};
		@(posedge clk);
		q <= '0;
	endtask
	// Negedge sampling keeps clear of the edge that updates data
	task automatic rc(string n, logic [7:0] ad, logic [7:0] e);
		acc(0, ad, 8'h00);
		@(negedge clk);
		chk(n, rd, e);
	endtask
	task automatic pc(logic [1:0] e);
		@(negedge clk);
		chk("pend", {6'h00, p1, p0}, {6'h00, e});
	endtask
	task automatic t_reset;
		rc("cfg", 8'he4, 8'h01);
		rc("prio", 8'hcf, 8'h00);
		rc("en", 8'he7, 8'h00);
		rc("tc", 8'h88, 8'h0a);
		rc("none", 8'h55, 8'h00);
	endtask
	task automatic t_regs;
		acc(1, 8'hcf, 8'hff);
		acc(1, 8'he7, 8'hff);
		rc("prio", 8'hcf, 8'h02);
		rc("en", 8'he7, 8'h02);
		chk("outs", {6'h00, pp, pe}, 8'h03);
		acc(1, 8'hcf, 8'hfd);
		rc("prio", 8'hcf, 8'h00);
	endtask
	task automatic t_level;
		for (int n = 0; n < 8; n++) begin
			acc(1, 8'he4, {1'b1, 3'(n), 1'b1, 3'(7 - n)});
			eic_pin_src_inst.hold(n, 1'b1, 4);
			pc(2'b10);
			eic_pin_src_inst.hold(n, 1'b0, 4);
			pc(2'b00);
		end
	endtask
	task automatic t_edge;
		acc(1, 8'he4, 8'h29);
		eic_pin_src_inst.hold(2, 1'b1, 1);
		acc(1, 8'h88, 8'h05);
		acc(1, 8'h88, 8'h05);
		pc(2'b00);
		eic_pin_src_inst.hold(1, 1'b1, 4);
		pc(2'b01);
		eic_pin_src_inst.hold(1, 1'b0, 4);
		pc(2'b01);
		@(posedge clk) v0 <= 1;
		@(posedge clk) v0 <= 0;
		pc(2'b00);
		eic_pin_src_inst.hold(2, 1'b0, 4);
		pc(2'b10);
		rc("tc", 8'h88, 8'h0d);
		@(posedge clk) v1 <= 1;
		@(posedge clk) v1 <= 0;
		pc(2'b00);
		acc(1, 8'h88, 8'h0f);
		pc(2'b11);
		acc(1, 8'h88, 8'h05);
		pc(2'b00);
	endtask
	initial begin
		#200us;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		t_reset();
		t_regs();
		t_level();
		t_edge();
		complete_run();
	end
endmodule

//--- verilog/eic_channel.sv
// Purpose: One external request channel: pin pick, polarity, detection
// Assumes: Port pins are plain inputs on the system clock
// Notes: Pending output is registered
`timescale 1ns/1ps
module eic_channel (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Pins and configuration
	input wire logic [7:0] port_pins_in,
	input wire eic_pkg::eic_chan_cfg_t cfg_in,
	// Pending flag control
	input wire logic vector_ack_in,
	input wire logic sw_wr_in,
	input wire logic sw_val_in,
	output logic pending_out
);

	logic sync1_q;
	logic sync2_q;
	logic active_prev_q;
	logic active_now;
	logic rise;

	// Observing only: the pin is never driven from here
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= port_pins_in[cfg_in.pin_sel];
			sync2_q <= sync1_q;
		end
	end

	// Inactive sense of the pin maps to zero here
	assign active_now = sync2_q ~^ cfg_in.active_high;
	assign rise = active_now & ~active_prev_q;

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			active_prev_q <= 1'b0;
		else
			active_prev_q <= active_now;
	end

	// Edge: set wins over vector clear and software write
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pending_out <= 1'b0;
		end else if (!cfg_in.edge_mode) begin
			pending_out <= active_now;
		end else if (rise) begin
			pending_out <= 1'b1;
		end else if (vector_ack_in) begin
			pending_out <= 1'b0;
		end else if (sw_wr_in) begin
			pending_out <= sw_val_in;
		end
	end

endmodule

//--- verilog/eic_pkg.sv
// Purpose: Shared constants and types for the external interrupt block
// Assumes: 8-bit special function register bus, one system clock
// Notes: Timer bits of the timer control register live elsewhere
package eic_pkg;

	// Register addresses
	localparam logic [7:0] EIC_PIN_POL_CFG_ADDR = 8'he4;
	localparam logic [7:0] EIC_EXT_PRIO_TWO_ADDR = 8'hcf;
	localparam logic [7:0] EIC_EXT_EN_TWO_ADDR = 8'he7;
	localparam logic [7:0] EIC_TIMER_CTRL_ADDR = 8'h88;

	// Reset values
	localparam logic [7:0] EIC_PIN_POL_CFG_RST = 8'h01;
	localparam logic EIC_PRIO_RST = 1'b0;
	localparam logic EIC_EN_RST = 1'b0;
	localparam logic [1:0] EIC_EDGE_MODE_RST = 2'h0;

	// Field positions
	localparam int EIC_SECOND_POL_BIT = 7;
	localparam int EIC_SECOND_SEL_LSB = 4;
	localparam int EIC_FIRST_POL_BIT = 3;
	localparam int EIC_FIRST_SEL_LSB = 0;
	localparam int EIC_PORT_MATCH_BIT = 1;
	localparam int EIC_FIRST_EDGE_BIT = 0;
	localparam int EIC_FIRST_PEND_BIT = 1;
	localparam int EIC_SECOND_EDGE_BIT = 2;
	localparam int EIC_SECOND_PEND_BIT = 3;
	localparam int EIC_SEL_W = 3;

	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eic_sfr_req_t;

	// Configuration of one external request channel
	typedef struct packed {
		logic [EIC_SEL_W-1:0] pin_sel;
		logic active_high;
		logic edge_mode;
	} eic_chan_cfg_t;

endpackage

//--- verilog/eic_top.sv
// Purpose: External interrupt configuration and detection for two inputs
// Assumes: Special function register bus, reads answered next cycle
// Notes: Only edge-mode and pending bits of the timer control register
`timescale 1ns/1ps

// Overview of operation
// - Priority bit 1 sets port-match high priority
// - Priority bits 7..2 read zero, ignore writes
// - Priority bit 0 reads zero, ignores writes
// - Config bit 7 sets second input polarity
// - Config bit 3 sets first input polarity
// - Type bit selects edge (1) or level (0)
// - Config bits 6..4 pick second input pin
// - Config bits 2..0 pick first input pin
// - Inputs only observe pins, never drive them
// - Pending flags at timer control bits 1, 3
// - Edge pending cleared when CPU vectors
// - Level pending follows the active input level
// - Enable bit 1 masks the port-match interrupt
module eic_top (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register bus
	input wire eic_pkg::eic_sfr_req_t sfr_req_in,
	output logic [7:0] sfr_rdata_out,
	// Port 0 pins, observed only
	input wire logic [7:0] port0_pins_in,
	// CPU vectoring acknowledges
	input wire logic first_ext_vector_in,
	input wire logic second_ext_vector_in,
	// Interrupt controller outputs
	output logic first_ext_pending_out,
	output logic second_ext_pending_out,
	output logic port_match_priority_out,
	output logic port_match_enable_out
);

	logic [7:0] pin_pol_cfg_q;
	logic first_ext_edge_mode_q;
	logic second_ext_edge_mode_q;
	logic wr_cfg;
	logic wr_prio;
	logic wr_en;
	logic wr_timer_control_reg;
	logic [7:0] rdata_d;
	eic_pkg::eic_chan_cfg_t first_cfg;
	eic_pkg::eic_chan_cfg_t second_cfg;

	assign wr_cfg = sfr_req_in.wr &&
		sfr_req_in.addr == eic_pkg::EIC_PIN_POL_CFG_ADDR;
	assign wr_prio = sfr_req_in.wr &&
		sfr_req_in.addr == eic_pkg::EIC_EXT_PRIO_TWO_ADDR;
	assign wr_en = sfr_req_in.wr &&
		sfr_req_in.addr == eic_pkg::EIC_EXT_EN_TWO_ADDR;
	assign wr_timer_control_reg = sfr_req_in.wr &&
		sfr_req_in.addr == eic_pkg::EIC_TIMER_CTRL_ADDR;

	// Pin, polarity configuration
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			pin_pol_cfg_q <= eic_pkg::EIC_PIN_POL_CFG_RST;
		else if (wr_cfg)
			pin_pol_cfg_q <= sfr_req_in.wdata;
	end

	// Only the single live bit is stored; the rest cannot hold a value
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			port_match_priority_out <= eic_pkg::EIC_PRIO_RST;
		else if (wr_prio)
			port_match_priority_out <=
				sfr_req_in.wdata[eic_pkg::EIC_PORT_MATCH_BIT];
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			port_match_enable_out <= eic_pkg::EIC_EN_RST;
		else if (wr_en)
			port_match_enable_out <=
				sfr_req_in.wdata[eic_pkg::EIC_PORT_MATCH_BIT];
	end

	// Edge or level selection
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			first_ext_edge_mode_q <= eic_pkg::EIC_EDGE_MODE_RST[0];
			second_ext_edge_mode_q <= eic_pkg::EIC_EDGE_MODE_RST[1];
		end else if (wr_timer_control_reg) begin
			first_ext_edge_mode_q <=
				sfr_req_in.wdata[eic_pkg::EIC_FIRST_EDGE_BIT];
			second_ext_edge_mode_q <=
				sfr_req_in.wdata[eic_pkg::EIC_SECOND_EDGE_BIT];
		end
	end

	always_comb begin
		first_cfg.pin_sel = pin_pol_cfg_q[eic_pkg::EIC_FIRST_SEL_LSB +:
			eic_pkg::EIC_SEL_W];
		first_cfg.active_high =
			pin_pol_cfg_q[eic_pkg::EIC_FIRST_POL_BIT];
		first_cfg.edge_mode = first_ext_edge_mode_q;
		second_cfg.pin_sel = pin_pol_cfg_q[eic_pkg::EIC_SECOND_SEL_LSB +:
			eic_pkg::EIC_SEL_W];
		second_cfg.active_high =
			pin_pol_cfg_q[eic_pkg::EIC_SECOND_POL_BIT];
		second_cfg.edge_mode = second_ext_edge_mode_q;
	end

	eic_channel u_first (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.port_pins_in(port0_pins_in),
		.cfg_in(first_cfg),
		.vector_ack_in(first_ext_vector_in),
		.sw_wr_in(wr_timer_control_reg),
		.sw_val_in(sfr_req_in.wdata[eic_pkg::EIC_FIRST_PEND_BIT]),
		.pending_out(first_ext_pending_out)
	);

	eic_channel u_second (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.port_pins_in(port0_pins_in),
		.cfg_in(second_cfg),
		.vector_ack_in(second_ext_vector_in),
		.sw_wr_in(wr_timer_control_reg),
		.sw_val_in(sfr_req_in.wdata[eic_pkg::EIC_SECOND_PEND_BIT]),
		.pending_out(second_ext_pending_out)
	);

	// Read mux; unknown addresses and unused bits read zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (sfr_req_in.addr)
			eic_pkg::EIC_PIN_POL_CFG_ADDR: rdata_d = pin_pol_cfg_q;
			eic_pkg::EIC_EXT_PRIO_TWO_ADDR:
				rdata_d[eic_pkg::EIC_PORT_MATCH_BIT] =
					port_match_priority_out;
			eic_pkg::EIC_EXT_EN_TWO_ADDR:
				rdata_d[eic_pkg::EIC_PORT_MATCH_BIT] =
					port_match_enable_out;
			eic_pkg::EIC_TIMER_CTRL_ADDR: begin
				rdata_d[eic_pkg::EIC_FIRST_EDGE_BIT] =
					first_ext_edge_mode_q;
				rdata_d[eic_pkg::EIC_FIRST_PEND_BIT] =
					first_ext_pending_out;
				rdata_d[eic_pkg::EIC_SECOND_EDGE_BIT] =
					second_ext_edge_mode_q;
				rdata_d[eic_pkg::EIC_SECOND_PEND_BIT] =
					second_ext_pending_out;
			end
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			sfr_rdata_out <= 8'h00;
		else if (sfr_req_in.rd)
			sfr_rdata_out <= rdata_d;
	end

endmodule
